// *** hdl/bsspc_pkg.sv ***
// package: constants and carrier types for the soft-start and phase-configuration block
//
// How it works
// - after enable, wait 1.5 ms init, then ramp target to commanded level.
// - power good held low in soft start; high when regulated and ramp done.
// - once high, power good drops only on disable or on undervoltage, overvoltage or overcurrent shutdown.
// - at power-up, measure ramp-select resistor code to choose ramp duration.
// - ramp supply undervoltage only counts while enabled; ignored when disabled.
// - with no disabled phases, all eight drive channels run.
// - at power-up, a sense input above threshold disables its drive channel.
// - active channel set from power-up is readable as phase status.
// - floating voltage command input puts command buffer output in high impedance.
// - eight drive channels, each individually enabled, giving zero to eight phases.
package bsspc_pkg;
  localparam int CLK_MHZ = 50;
  localparam int INIT_TIME_US_X10 = 15000;
  localparam int INIT_CYCLES = INIT_TIME_US_X10 * CLK_MHZ / 10;
  localparam int RAMP_STEP_US = 1;
  localparam int RAMP_STEP_CYCLES = RAMP_STEP_US * CLK_MHZ;
  localparam int NUM_PHASES = 8;
  localparam int RSEL_W = 3;
  localparam int LEVEL_W = 8;
  localparam logic [7:0] PHASE_RESET = 8'hff;
  localparam logic [2:0] RSEL_RESET = 3'h0;
  localparam logic [7:0] LEVEL_RESET = 8'h00;

  typedef enum logic [2:0] {
    BSSPC_OFF = 3'b000,
    BSSPC_INIT = 3'b001,
    BSSPC_RAMP = 3'b010,
    BSSPC_SETTLE = 3'b011,
    BSSPC_GOOD = 3'b100,
    BSSPC_FAULT = 3'b101
  } bsspc_state_t;

  typedef struct packed {
    logic uvlo;
    logic ovp;
    logic ocp;
  } bsspc_fault_t;
endpackage

// *** hdl/bsspc_sync.sv ***
// three-stage synchroniser with agreement filter for one pin
`timescale 1ns/10ps
`default_nettype none
module bsspc_sync #(
  parameter logic RESET_VAL = 1'b0
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic pin_i,
  output logic level_o
);
  logic s1_q;
  logic s2_q;
  logic s3_q;
  logic level_q;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s1_q <= RESET_VAL;
      s2_q <= RESET_VAL;
      s3_q <= RESET_VAL;
      level_q <= RESET_VAL;
    end else begin
      s1_q <= pin_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        level_q <= s3_q;
      end
    end
  end
  assign level_o = level_q;
endmodule
`default_nettype wire

// *** hdl/bsspc_ramp.sv ***
// output target ramp generator: one step per tick, rate from latched ramp code
`timescale 1ns/10ps
`default_nettype none
module bsspc_ramp #(
  parameter int LEVEL_W = bsspc_pkg::LEVEL_W,
  parameter int STEP_CYCLES = bsspc_pkg::RAMP_STEP_CYCLES
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic run_i,
  input wire logic [bsspc_pkg::RSEL_W-1:0] rsel_i,
  input wire logic [LEVEL_W-1:0] goal_i,
  output logic [LEVEL_W-1:0] level_o,
  output logic done_o
);
  logic [15:0] tick_q;
  logic [15:0] tick_d;
  logic [LEVEL_W-1:0] level_q;
  logic [15:0] period;
  wire tick_hit = (tick_q >= period);
  wire at_goal = (level_q == goal_i);
  // longer ramp code stretches the step period, doubling per code
  assign period = 16'(STEP_CYCLES) << rsel_i;
  assign tick_d = (!run_i || tick_hit) ? 16'h0000 : 16'(tick_q + 16'h0001);
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tick_q <= 16'h0000;
      level_q <= bsspc_pkg::LEVEL_RESET;
    end else begin
      tick_q <= tick_d;
      if (!run_i) begin
        level_q <= bsspc_pkg::LEVEL_RESET;
      end else if (tick_hit && !at_goal) begin
        level_q <= (level_q < goal_i) ? LEVEL_W'(level_q + 1'b1) : LEVEL_W'(level_q - 1'b1);
      end
    end
  end
  assign level_o = level_q;
  assign done_o = run_i && at_goal;
endmodule
`default_nettype wire

// *** hdl/bsspc_top.sv ***
// soft-start sequencer, power-up phase detection and command buffer control
`timescale 1ns/10ps
`default_nettype none
module bsspc_top #(
  parameter int INIT_CYCLES = bsspc_pkg::INIT_CYCLES,
  parameter int NUM_PHASES = bsspc_pkg::NUM_PHASES,
  parameter int LEVEL_W = bsspc_pkg::LEVEL_W
) (
  input wire logic MCLK_I,
  input wire logic RST_N_I,
  input wire logic ENABLE_I,
  input wire logic [NUM_PHASES-1:0] PHASE_CURRENT_SENSE_POS_ABOVE_I,
  input wire logic [bsspc_pkg::RSEL_W-1:0] RAMP_TIME_SELECT_CODE_I,
  input wire logic [LEVEL_W-1:0] DUTY_VOLTAGE_COMMAND_LEVEL_I,
  input wire logic DUTY_VOLTAGE_COMMAND_FLOAT_I,
  input wire logic DUTY_VOLTAGE_COMMAND_I,
  input wire logic RAMP_SUPPLY_SENSE_LOW_I,
  input wire logic OVERVOLTAGE_I,
  input wire logic OVERCURRENT_I,
  input wire logic IN_REGULATION_I,
  output logic POWER_GOOD_OUT_O,
  output logic [NUM_PHASES-1:0] PHASE_DRIVE_ENABLE_O,
  output logic [NUM_PHASES-1:0] PHASE_STATUS_O,
  output logic [bsspc_pkg::RSEL_W-1:0] RAMP_SELECT_O,
  output logic [LEVEL_W-1:0] REFERENCE_TARGET_O,
  output logic COMMAND_BUFFER_OUT_O,
  output logic COMMAND_BUFFER_OE_O,
  output logic [2:0] FAULT_O
);
  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic en_s;
  logic float_s;
  logic cmd_s;
  logic uv_s;
  logic ov_s;
  logic oc_s;
  logic reg_s;
  logic [NUM_PHASES-1:0] csp_s;
  logic [bsspc_pkg::RSEL_W-1:0] rsel_s;

  bsspc_sync u_en (.clk_i(MCLK_I), .rst_n_i(RST_N_I), .pin_i(ENABLE_I), .level_o(en_s));
  bsspc_sync #(.RESET_VAL(1'b1)) u_flt (.clk_i(MCLK_I), .rst_n_i(RST_N_I),
    .pin_i(DUTY_VOLTAGE_COMMAND_FLOAT_I), .level_o(float_s));
  bsspc_sync u_cmd (.clk_i(MCLK_I), .rst_n_i(RST_N_I), .pin_i(DUTY_VOLTAGE_COMMAND_I),
    .level_o(cmd_s));
  bsspc_sync u_uv (.clk_i(MCLK_I), .rst_n_i(RST_N_I), .pin_i(RAMP_SUPPLY_SENSE_LOW_I),
    .level_o(uv_s));
  bsspc_sync u_ov (.clk_i(MCLK_I), .rst_n_i(RST_N_I), .pin_i(OVERVOLTAGE_I), .level_o(ov_s));
  bsspc_sync u_oc (.clk_i(MCLK_I), .rst_n_i(RST_N_I), .pin_i(OVERCURRENT_I), .level_o(oc_s));
  bsspc_sync u_rg (.clk_i(MCLK_I), .rst_n_i(RST_N_I), .pin_i(IN_REGULATION_I),
    .level_o(reg_s));

  genvar gi;
  generate
    for (gi = 0; gi < NUM_PHASES; gi++) begin : g_csp
      bsspc_sync u_csp (.clk_i(MCLK_I), .rst_n_i(RST_N_I),
        .pin_i(PHASE_CURRENT_SENSE_POS_ABOVE_I[gi]), .level_o(csp_s[gi]));
    end
    for (gi = 0; gi < bsspc_pkg::RSEL_W; gi++) begin : g_rsel
      bsspc_sync u_rs (.clk_i(MCLK_I), .rst_n_i(RST_N_I),
        .pin_i(RAMP_TIME_SELECT_CODE_I[gi]), .level_o(rsel_s[gi]));
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // power-up capture: wait for synchronisers to fill, then latch once
  logic [2:0] boot_cnt_q;
  logic boot_done_q;
  logic [NUM_PHASES-1:0] phase_q;
  logic [bsspc_pkg::RSEL_W-1:0] rsel_q;
  wire boot_take = !boot_done_q && (boot_cnt_q == 3'h7);

  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      boot_cnt_q <= 3'h0;
      boot_done_q <= 1'b0;
      phase_q <= bsspc_pkg::PHASE_RESET;
      rsel_q <= bsspc_pkg::RSEL_RESET;
    end else begin
      if (!boot_done_q) begin
        boot_cnt_q <= 3'(boot_cnt_q + 3'h1);
      end
      if (boot_take) begin
        boot_done_q <= 1'b1;
        phase_q <= ~csp_s;
        rsel_q <= rsel_s;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // fault detection
  // a supply undervoltage is meaningless while the block is disabled, so gate it with enable
  wire uvlo_act = en_s && uv_s;
  bsspc_pkg::bsspc_fault_t flt;
  assign flt.uvlo = uvlo_act;
  assign flt.ovp = ov_s;
  assign flt.ocp = oc_s;
  wire any_fault = flt.uvlo || flt.ovp || flt.ocp;

  ////////////////////////////////////////////////////////////////////////////
  // soft-start sequencer
  bsspc_pkg::bsspc_state_t st_q;
  bsspc_pkg::bsspc_state_t st_d;
  logic [31:0] init_cnt_q;
  logic [31:0] init_cnt_d;
  logic ramp_done;
  logic [LEVEL_W-1:0] level;
  logic [LEVEL_W-1:0] goal;
  wire init_end = (init_cnt_q >= 32'(INIT_CYCLES - 1));
  wire ramp_run = (st_q == bsspc_pkg::BSSPC_RAMP) || (st_q == bsspc_pkg::BSSPC_SETTLE) ||
    (st_q == bsspc_pkg::BSSPC_GOOD);

  // floating command boots to mid-scale
  assign goal = float_s ? LEVEL_W'(1 << (LEVEL_W - 1)) : DUTY_VOLTAGE_COMMAND_LEVEL_I;
  assign init_cnt_d = (st_q == bsspc_pkg::BSSPC_INIT) ? 32'(init_cnt_q + 32'h1) : 32'h0;

  always_comb begin
    st_d = st_q;
    unique case (st_q)
      bsspc_pkg::BSSPC_OFF: begin
        if (en_s && boot_done_q) begin
          st_d = bsspc_pkg::BSSPC_INIT;
        end
      end
      bsspc_pkg::BSSPC_INIT: begin
        if (!en_s) begin
          st_d = bsspc_pkg::BSSPC_OFF;
        end else if (any_fault) begin
          st_d = bsspc_pkg::BSSPC_FAULT;
        end else if (init_end) begin
          st_d = bsspc_pkg::BSSPC_RAMP;
        end
      end
      bsspc_pkg::BSSPC_RAMP: begin
        if (!en_s) begin
          st_d = bsspc_pkg::BSSPC_OFF;
        end else if (any_fault) begin
          st_d = bsspc_pkg::BSSPC_FAULT;
        end else if (ramp_done) begin
          st_d = bsspc_pkg::BSSPC_SETTLE;
        end
      end
      bsspc_pkg::BSSPC_SETTLE: begin
        if (!en_s) begin
          st_d = bsspc_pkg::BSSPC_OFF;
        end else if (any_fault) begin
          st_d = bsspc_pkg::BSSPC_FAULT;
        end else if (reg_s) begin
          st_d = bsspc_pkg::BSSPC_GOOD;
        end
      end
      bsspc_pkg::BSSPC_GOOD: begin
        // power good stays up through later command changes; only faults or disable drop it
        if (any_fault) begin
          st_d = bsspc_pkg::BSSPC_FAULT;
        end else if (!en_s) begin
          st_d = bsspc_pkg::BSSPC_OFF;
        end
      end
      bsspc_pkg::BSSPC_FAULT: begin
        // latched shutdown until enable is cycled
        if (!en_s) begin
          st_d = bsspc_pkg::BSSPC_OFF;
        end
      end
      default: st_d = bsspc_pkg::BSSPC_OFF;
    endcase
  end

  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      st_q <= bsspc_pkg::BSSPC_OFF;
      init_cnt_q <= 32'h0;
    end else begin
      st_q <= st_d;
      init_cnt_q <= init_cnt_d;
    end
  end

  bsspc_ramp #(.LEVEL_W(LEVEL_W)) u_ramp (
    .clk_i(MCLK_I),
    .rst_n_i(RST_N_I),
    .run_i(ramp_run),
    .rsel_i(rsel_q),
    .goal_i(goal),
    .level_o(level),
    .done_o(ramp_done)
  );

  ////////////////////////////////////////////////////////////////////////////
  // registered outputs
  wire drive_on = ramp_run;
  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      POWER_GOOD_OUT_O <= 1'b0;
      PHASE_DRIVE_ENABLE_O <= '0;
      PHASE_STATUS_O <= '0;
      RAMP_SELECT_O <= bsspc_pkg::RSEL_RESET;
      REFERENCE_TARGET_O <= bsspc_pkg::LEVEL_RESET;
      COMMAND_BUFFER_OUT_O <= 1'b0;
      COMMAND_BUFFER_OE_O <= 1'b0;
      FAULT_O <= 3'h0;
    end else begin
      POWER_GOOD_OUT_O <= (st_d == bsspc_pkg::BSSPC_GOOD);
      PHASE_DRIVE_ENABLE_O <= drive_on ? phase_q : '0;
      PHASE_STATUS_O <= boot_done_q ? phase_q : '0;
      RAMP_SELECT_O <= rsel_q;
      REFERENCE_TARGET_O <= level;
      COMMAND_BUFFER_OUT_O <= float_s ? 1'b0 : cmd_s;
      COMMAND_BUFFER_OE_O <= !float_s;
      if (st_q != bsspc_pkg::BSSPC_FAULT) begin
        FAULT_O <= flt;
      end
    end
  end
endmodule
`default_nettype wire

// *** verification/bsspc_top_props.sv ***
// assertion checker for the soft-start and phase-configuration block
`timescale 1ns/10ps
`default_nettype none
module bsspc_top_props #(
  parameter int INIT_CYCLES = 100
) (
  input wire logic MCLK_I,
  input wire logic RST_N_I,
  input wire logic ENABLE_I,
  input wire logic DUTY_VOLTAGE_COMMAND_FLOAT_I,
  input wire logic RAMP_SUPPLY_SENSE_LOW_I,
  input wire logic OVERVOLTAGE_I,
  input wire logic OVERCURRENT_I,
  input wire logic POWER_GOOD_OUT_O,
  input wire logic [7:0] PHASE_DRIVE_ENABLE_O,
  input wire logic [7:0] PHASE_STATUS_O,
  input wire logic [2:0] RAMP_SELECT_O,
  input wire logic [7:0] REFERENCE_TARGET_O,
  input wire logic COMMAND_BUFFER_OE_O,
  input wire logic [2:0] FAULT_O
);
  default clocking @(posedge MCLK_I);
  endclocking
  default disable iff (!RST_N_I);
  // saturates just past the init length so it never wraps on long runs
  int en_cnt_q;
  wire quiet = ENABLE_I && !OVERVOLTAGE_I && !OVERCURRENT_I && !RAMP_SUPPLY_SENSE_LOW_I;
  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) en_cnt_q <= 0;
    else if (!ENABLE_I) en_cnt_q <= 0;
    else if (en_cnt_q <= INIT_CYCLES) en_cnt_q <= en_cnt_q + 1;
  end
  a_init_wait: assert property (REFERENCE_TARGET_O != 0 && $past(REFERENCE_TARGET_O) == 0
    |-> en_cnt_q > INIT_CYCLES) else $error("target moved before init ended");
  a_pg_holds: assert property ((POWER_GOOD_OUT_O && quiet) [*8] |=> POWER_GOOD_OUT_O)
    else $error("power good dropped without a fault");
  a_pg_drive: assert property (POWER_GOOD_OUT_O |-> PHASE_DRIVE_ENABLE_O == PHASE_STATUS_O)
    else $error("drive set differs from status while good");
  a_drive_subset: assert property ((PHASE_DRIVE_ENABLE_O & ~PHASE_STATUS_O) == 8'h00)
    else $error("disabled channel driven");
  a_status_hold: assert property (PHASE_STATUS_O != 0 |=> $stable(PHASE_STATUS_O))
    else $error("phase status changed after capture");
  a_ramp_hold: assert property (PHASE_STATUS_O != 0 |=> $stable(RAMP_SELECT_O))
    else $error("ramp select changed after capture");
  a_float_hiz: assert property (DUTY_VOLTAGE_COMMAND_FLOAT_I [*6] |-> !COMMAND_BUFFER_OE_O)
    else $error("buffer driven while command floats");
  a_uvlo_off: assert property (!ENABLE_I [*8] |-> !FAULT_O[2])
    else $error("supply undervoltage counted while disabled");
  c_pg_rise: cover property ($rose(POWER_GOOD_OUT_O));
  c_fault: cover property (FAULT_O != 3'h0);
  c_hiz: cover property ($fell(COMMAND_BUFFER_OE_O));
endmodule
bind bsspc_top bsspc_top_props #(.INIT_CYCLES(INIT_CYCLES)) props_u (.MCLK_I, .RST_N_I,
  .ENABLE_I, .DUTY_VOLTAGE_COMMAND_FLOAT_I, .RAMP_SUPPLY_SENSE_LOW_I, .OVERVOLTAGE_I,
  .OVERCURRENT_I, .POWER_GOOD_OUT_O, .PHASE_DRIVE_ENABLE_O, .PHASE_STATUS_O,
  .RAMP_SELECT_O, .REFERENCE_TARGET_O, .COMMAND_BUFFER_OE_O, .FAULT_O);
`default_nettype wire

// *** verification/bsspc_stage_model.sv ***
// behavioural power stage: reports regulation once the target sits on its goal
`timescale 1ns/10ps
`default_nettype none
module bsspc_stage_model (
  input wire logic clk_i,
  input wire logic [7:0] target_i,
  input wire logic [7:0] goal_i,
  input wire logic slow_i,
  input wire logic droop_i,
  output logic in_reg_o
);
  int hold_q = 0;
  always @(posedge clk_i) begin
    hold_q <= (target_i == goal_i && target_i != 8'h00) ? hold_q + 1 : 0;
  end
  // a load step knocks the output out of regulation while droop_i is high
  assign in_reg_o = !droop_i && hold_q > (slow_i ? 6 : 2);
endmodule
`default_nettype wire

// *** verification/tb_bsspc_top.sv ***
// self-checking bench for the soft-start and phase-configuration block
`timescale 1ns/10ps
`default_nettype none
module tb_bsspc_top;
  localparam int INIT = 100;
  typedef struct {string name; int kind; logic [7:0] exp;} bsspc_note_t;
  bsspc_note_t notes[$];
  event chk_ev;
  int fail_count = 0, n_compared = 0, cyc = 0;
  logic clk = 1'b0, rst_n = 1'b0, en = 1'b0, flt = 1'b0, cmd = 1'b0, slow = 1'b0, droop = 1'b0;
  logic [7:0] sense = 8'h00, goal = 8'h01, lfsr = 8'h5f, stat_exp = 8'hff;
  logic [2:0] code = 3'h0, faults = 3'h0;
  wire in_reg, pg, cbo, oe;
  wire [7:0] drive, status, target;
  wire [2:0] rsel, fault;
  bsspc_top #(.INIT_CYCLES(INIT)) dut_u (.MCLK_I(clk), .RST_N_I(rst_n), .ENABLE_I(en),
    .PHASE_CURRENT_SENSE_POS_ABOVE_I(sense), .RAMP_TIME_SELECT_CODE_I(code),
    .DUTY_VOLTAGE_COMMAND_LEVEL_I(goal), .DUTY_VOLTAGE_COMMAND_FLOAT_I(flt),
    .DUTY_VOLTAGE_COMMAND_I(cmd), .RAMP_SUPPLY_SENSE_LOW_I(faults[2]),
    .OVERVOLTAGE_I(faults[1]), .OVERCURRENT_I(faults[0]), .IN_REGULATION_I(in_reg),
    .POWER_GOOD_OUT_O(pg), .PHASE_DRIVE_ENABLE_O(drive), .PHASE_STATUS_O(status),
    .RAMP_SELECT_O(rsel), .REFERENCE_TARGET_O(target), .COMMAND_BUFFER_OUT_O(cbo),
    .COMMAND_BUFFER_OE_O(oe), .FAULT_O(fault));
  bsspc_stage_model stage_u (.clk_i(clk), .target_i(target), .goal_i(goal), .slow_i(slow),
    .droop_i(droop), .in_reg_o(in_reg));
  initial forever #10 clk = ~clk;
  function automatic logic [7:0] step(input logic [7:0] x);
    return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
  endfunction
  always @(negedge clk) begin
    lfsr <= step(lfsr);
    cmd <= lfsr[0];
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      fail_count++;
      summarize();
    end
  end
  ////////////////////////////////////////////////////////////
  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic compare(input string name, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", name, e, g);
    end
  endtask
  function automatic logic [7:0] observe(input int k);
    case (k)
      0: return status;
      1: return {5'h00, rsel};
      2: return target;
      3: return {7'h00, pg};
      4: return drive;
      5: return {5'h00, fault};
      6: return {7'h00, oe};
      default: return {7'h00, cbo};
    endcase
  endfunction
  initial forever begin
    @(chk_ev);
    while (notes.size() > 0) begin
      bsspc_note_t n;
      n = notes.pop_front();
      compare(n.name, n.exp, observe(n.kind));
    end
  end
  task automatic note(input string name, input int k, input logic [7:0] e);
    notes.push_back('{name, k, e});
    -> chk_ev;
    #1;
  endtask
  // straps are flipped after capture so a design that keeps sampling shows it
  task automatic boot(input logic [7:0] s, input logic [2:0] c);
    @(negedge clk);
    rst_n = 1'b0;
    en = 1'b0;
    sense = s;
    code = c;
    stat_exp = ~s;
    repeat (4) @(negedge clk);
    rst_n = 1'b1;
    repeat (14) @(negedge clk);
    sense = ~s;
    code = ~c;
    repeat (6) @(negedge clk);
    note("phase status", 0, ~s);
    note("ramp select", 1, {5'h00, c});
  endtask
  task automatic wait_pg(input logic want, input int lim);
    for (int i = 0; i < lim && pg !== want; i++) @(negedge clk);
  endtask
  task automatic start(input logic [7:0] g);
    @(negedge clk);
    goal = g;
    en = 1'b1;
    repeat (INIT) @(negedge clk);
    note("target during init", 2, 8'h00);
    note("power good during init", 3, 8'h00);
    wait_pg(1'b1, 2500);
    note("power good", 3, 8'h01);
    note("target", 2, g);
    note("drive channels", 4, stat_exp);
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    boot(8'h00, 3'h0);
    start(8'h03);
    droop = 1'b1;
    repeat (12) @(negedge clk);
    droop = 1'b0;
    note("power good after droop", 3, 8'h01);
    $display("test startup done");
    for (int k = 0; k < 3; k++) begin
      boot(lfsr & 8'hfe, {2'b00, lfsr[1]});
      slow = lfsr[2];
      start((lfsr & 8'h0f) | 8'h01);
      faults = 3'b100 >> k;
      wait_pg(1'b0, 20);
      note("power good on fault", 3, 8'h00);
      note("fault code", 5, {5'h00, faults});
      faults = 3'h0;
      en = 1'b0;
      repeat (10) @(negedge clk);
    end
    $display("test faults done");
    faults = 3'b100;
    repeat (12) @(negedge clk);
    note("undervoltage while disabled", 5, 8'h00);
    faults = 3'h0;
    flt = 1'b1;
    repeat (8) @(negedge clk);
    note("buffer enable floating", 6, 8'h00);
    note("buffer data floating", 7, 8'h00);
    flt = 1'b0;
    repeat (8) @(negedge clk);
    note("buffer enable driven", 6, 8'h01);
    $display("test buffer done");
    summarize();
  end
endmodule
`default_nettype wire
